// ---- hdl/rsc_defines.svh ----
// Offsets, field positions, reset values and timing counts for reset_startup_control
// Included by rsc_top and the bench top; definitions only
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// Register byte offsets
`define RSC_OFF_PWR 12'h000
`define RSC_OFF_RUNRST 12'h004
`define RSC_OFF_FLAGCTL 12'h008
`define RSC_OFF_STATUS 12'h00c

// Field positions
`define RSC_PWR_MULT_LSB 0
`define RSC_PWR_DIV_LSB 6
`define RSC_RUNRST_EN_BIT 0
`define RSC_FLAGCTL_MS_BIT 0
`define RSC_FLAGCTL_PU_LSB 1

// Reset values
`define RSC_PWR_MULT_RST 6'h10
`define RSC_PWR_DIV_RST 2'h0
`define RSC_RESET_VECTOR 32'h0009_0000

// Lock delay in reference clock cycles
`define RSC_PLL_LOCK_CYCLES 4096
`define RSC_LOCK_LAST 12'hfff

`endif

// ---- hdl/rsc_pkg.sv ----
// Types for reset_startup_control
// Used by name only, never imported
package rsc_pkg;

  typedef enum logic [1:0] {
    st_reset = 2'b00,
    st_lock = 2'b01,
    st_run = 2'b10
  } rsc_state_e;

  typedef struct packed {
    rsc_state_e state;
    logic [11:0] cnt;
    logic [1:0] boot_mode;
    logic [1:0] clk_ratio;
    logic [5:0] mult;
    logic [1:0] div;
    logic runrst_en;
    logic ms_mode;
    logic [1:0] pu_sel;
    logic [1:0] pu_out;
    logic core_run;
    logic fetch_start;
    logic [31:0] fetch_addr;
    logic rst_pin_o;
    logic rst_pin_oe_n;
    logic mem_sel_two_n;
    logic mem_sel_three_n;
    logic tap_reset;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rsc_state_s;

endpackage

// ---- hdl/rsc_sync.sv ----
// Two flip-flop synchroniser for a bundle of pin levels
// Assumes each bit is an independent level; resets to all zeros
`timescale 1ns/100ps
`default_nettype none

module rsc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } rsc_sync_s;

  rsc_sync_s s_q;
  rsc_sync_s s_d;

  always_comb begin
    s_d.meta = d;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.sync;

endmodule

`default_nettype wire

// ---- hdl/rsc_top.sv ----
// Start-up and reset control: reset pin, straps, lock delay, running reset, memory selects
// Assumes pclk is the continuous reference clock; pins are asynchronous to it
`timescale 1ns/100ps
`default_nettype none
`include "rsc_defines.svh"

module rsc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic reset_pin_n,
  input wire logic [1:0] boot_cfg,
  input wire logic [1:0] clk_cfg,
  input wire logic trst_n,
  input wire logic reset_output_i,
  output logic reset_output_o,
  output logic reset_output_oe_n,
  output logic memory_select_two_n,
  output logic memory_select_three_n,
  output logic [1:0] ms_pullup_en,
  // Core side
  input wire logic mem_req,
  input wire logic [1:0] mem_bank,
  output logic core_run,
  output logic core_fetch_start,
  output logic [31:0] core_fetch_addr,
  output logic [1:0] boot_mode,
  output logic [1:0] startup_ratio,
  output logic [5:0] pll_mult,
  output logic [1:0] pll_div,
  output logic tap_reset
);

  function automatic logic bank_sel(input logic req, input logic [1:0] bank, input logic [1:0] tgt);
    bank_sel = req && (bank == tgt);
  endfunction

  logic [6:0] pins_s;
  logic ext_rst_n_s;
  logic [1:0] boot_s;
  logic [1:0] clk_s;
  logic trst_n_s;
  logic runrst_s;
  logic hold;
  logic setup;
  logic wr;
  rsc_pkg::rsc_state_s s_q;
  rsc_pkg::rsc_state_s s_d;

  rsc_sync #(
    .W(7)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({reset_pin_n, boot_cfg, clk_cfg, trst_n, reset_output_i}),
    .q(pins_s)
  );

  assign ext_rst_n_s = pins_s[6];
  assign boot_s = pins_s[5:4];
  assign clk_s = pins_s[3:2];
  assign trst_n_s = pins_s[1];
  assign runrst_s = pins_s[0];
  // Core held by the reset pin or, when enabled, by the running-reset pin
  assign hold = !ext_rst_n_s || (s_q.runrst_en && !runrst_s);
  assign setup = psel && !penable;
  assign wr = psel && penable && s_q.pready && pwrite;

  always_comb begin
    s_d = s_q;
    s_d.fetch_start = 1'b0;
    unique case (s_q.state)
      rsc_pkg::st_reset: begin
        s_d.core_run = 1'b0;
        s_d.cnt = '0;
        s_d.boot_mode = boot_s;
        s_d.clk_ratio = clk_s;
        s_d.mult = `RSC_PWR_MULT_RST;
        s_d.div = `RSC_PWR_DIV_RST;
        if (!hold) begin
          s_d.state = rsc_pkg::st_lock;
        end
      end
      rsc_pkg::st_lock: begin
        s_d.cnt = s_q.cnt + 12'h001;
        if (s_q.cnt == `RSC_LOCK_LAST) begin
          s_d.state = rsc_pkg::st_run;
          s_d.core_run = 1'b1;
          s_d.fetch_start = 1'b1;
        end
      end
      rsc_pkg::st_run: begin
      end
      default: begin
        s_d.state = rsc_pkg::st_reset;
      end
    endcase
    if (hold) begin
      s_d.state = rsc_pkg::st_reset;
      s_d.core_run = 1'b0;
      s_d.cnt = '0;
    end
    if (!ext_rst_n_s) begin
      s_d.runrst_en = 1'b0;
      s_d.ms_mode = 1'b0;
      s_d.pu_sel = 2'h0;
    end
    // APB: answer in first access cycle, update at access edge
    s_d.pready = setup;
    if (setup) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      unique case (paddr)
        `RSC_OFF_PWR: s_d.prdata = {24'h000000, s_q.div, s_q.mult};
        `RSC_OFF_RUNRST: s_d.prdata = {31'h00000000, s_q.runrst_en};
        `RSC_OFF_FLAGCTL: s_d.prdata = {29'h00000000, s_q.pu_sel, s_q.ms_mode};
        `RSC_OFF_STATUS: s_d.prdata = {24'h000000, runrst_s, s_q.core_run, s_q.clk_ratio,
                                       s_q.boot_mode, s_q.state};
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (wr && ext_rst_n_s) begin
      if (paddr == `RSC_OFF_PWR && s_q.state == rsc_pkg::st_run) begin
        s_d.mult = pwdata[`RSC_PWR_MULT_LSB +: 6];
        s_d.div = pwdata[`RSC_PWR_DIV_LSB +: 2];
      end
      if (paddr == `RSC_OFF_RUNRST) begin
        s_d.runrst_en = pwdata[`RSC_RUNRST_EN_BIT];
      end
      if (paddr == `RSC_OFF_FLAGCTL) begin
        s_d.ms_mode = pwdata[`RSC_FLAGCTL_MS_BIT];
        s_d.pu_sel = pwdata[`RSC_FLAGCTL_PU_LSB +: 2];
      end
    end
    s_d.fetch_addr = `RSC_RESET_VECTOR;
    s_d.pu_out = s_d.ms_mode ? s_d.pu_sel : 2'h0;
    s_d.rst_pin_o = (s_d.state == rsc_pkg::st_run);
    s_d.rst_pin_oe_n = s_d.runrst_en;
    s_d.mem_sel_two_n = !(s_q.ms_mode && bank_sel(mem_req, mem_bank, 2'h2));
    s_d.mem_sel_three_n = !(s_q.ms_mode && bank_sel(mem_req, mem_bank, 2'h3));
    s_d.tap_reset = !trst_n_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mult <= `RSC_PWR_MULT_RST;
      s_q.div <= `RSC_PWR_DIV_RST;
      s_q.fetch_addr <= `RSC_RESET_VECTOR;
      s_q.rst_pin_oe_n <= 1'b0;
      s_q.mem_sel_two_n <= 1'b1;
      s_q.mem_sel_three_n <= 1'b1;
      s_q.tap_reset <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign reset_output_o = s_q.rst_pin_o;
  assign reset_output_oe_n = s_q.rst_pin_oe_n;
  assign memory_select_two_n = s_q.mem_sel_two_n;
  assign memory_select_three_n = s_q.mem_sel_three_n;
  assign ms_pullup_en = s_q.pu_out;
  assign core_run = s_q.core_run;
  assign core_fetch_start = s_q.fetch_start;
  assign core_fetch_addr = s_q.fetch_addr;
  assign boot_mode = s_q.boot_mode;
  assign startup_ratio = s_q.clk_ratio;
  assign pll_mult = s_q.mult;
  assign pll_div = s_q.div;
  assign tap_reset = s_q.tap_reset;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_lock_count: assert property (
    (s_q.state == rsc_pkg::st_lock && s_q.cnt != `RSC_LOCK_LAST && !hold)
      |=> (s_q.state == rsc_pkg::st_lock && s_q.cnt == $past(s_q.cnt) + 12'h001))
    else $error("lock count did not advance");
  chk_run_entry: assert property (
    $rose(s_q.core_run) |-> ($past(s_q.cnt) == `RSC_LOCK_LAST && $past(s_q.state) == rsc_pkg::st_lock))
    else $error("core started before lock delay");
  chk_vector_fetch: assert property (
    $rose(s_q.core_run) |-> (s_q.fetch_start && s_q.fetch_addr == `RSC_RESET_VECTOR))
    else $error("no reset vector fetch at start");
  chk_ratio_strap: assert property (
    (s_q.state == rsc_pkg::st_reset) |=> (s_q.clk_ratio == $past(clk_s)))
    else $error("clock ratio not taken from pins");
  chk_pwr_write: assert property (
    (wr && ext_rst_n_s && paddr == `RSC_OFF_PWR && s_q.state == rsc_pkg::st_run && !hold)
      |=> (s_q.mult == $past(pwdata[5:0]) && s_q.div == $past(pwdata[7:6])))
    else $error("multiplier write lost");
  chk_pin_default: assert property (
    (!ext_rst_n_s) |=> (!s_q.rst_pin_oe_n && !s_q.rst_pin_o))
    else $error("reset pin not an output in reset");
  chk_runrst_switch: assert property (
    (wr && ext_rst_n_s && paddr == `RSC_OFF_RUNRST && pwdata[0]) |=> s_q.rst_pin_oe_n)
    else $error("pin did not become running reset input");
  chk_pullup_gate: assert property (
    (!s_q.ms_mode) |-> (s_q.pu_out == 2'h0))
    else $error("pull-up on outside select mode");
  chk_tap_reset: assert property (
    (!trst_n_s) |=> s_q.tap_reset)
    else $error("test reset ignored");
  chk_ms_onehot: assert property (
    (!s_q.mem_sel_two_n || !s_q.mem_sel_three_n)
      |-> (s_q.mem_sel_two_n != s_q.mem_sel_three_n && $past(mem_req)
           && $past(mem_bank) == (s_q.mem_sel_two_n ? 2'h3 : 2'h2)))
    else $error("memory select for wrong bank");
  chk_hold_halt: assert property (
    hold |=> (!s_q.core_run && s_q.state == rsc_pkg::st_reset))
    else $error("core ran during reset");

  cov_reach_run: cover property ($rose(s_q.core_run));
  cov_run_reset: cover property (s_q.runrst_en && !runrst_s && s_q.core_run);
  cov_pwr_wr: cover property (wr && paddr == `RSC_OFF_PWR && s_q.state == rsc_pkg::st_run);

endmodule

`default_nettype wire

// ---- testbench/rsc_far_side.sv ----
// Far-side model: reset supervisor, strap pins, test reset and shared reset pin
// Assumes the bench steers it through command inputs changed after pclk edges
`timescale 1ns/100ps
`default_nettype none

module rsc_far_side (
  // Commands from the bench
  input wire logic hold_rst,
  input wire logic pull_run,
  input wire logic [3:0] straps,
  input wire logic tap_rst,
  // Device side of the pins
  input wire logic reset_output_o,
  input wire logic reset_output_oe_n,
  output logic reset_pin_n,
  output logic [1:0] boot_cfg,
  output logic [1:0] clk_cfg,
  output logic trst_n,
  output logic reset_output_i
);
  // Reset held low from power-up until the bench lets go
  assign reset_pin_n = !hold_rst;
  // Straps are only moved while reset is held
  assign boot_cfg = straps[3:2];
  assign clk_cfg = straps[1:0];
  // Test reset pulsed low; test clock held low, not a pin here
  assign trst_n = !tap_rst;
  // Shared pin: device drives it, else pull-up unless pulled low
  assign reset_output_i = reset_output_oe_n ? !pull_run : reset_output_o;
endmodule

`default_nettype wire

// ---- testbench/reset_startup_control_tb_top.sv ----
// Bench for rsc_top: APB register tasks and start-up sequences
// Assumes rsc_far_side as the pin partner and a continuous 250 MHz pclk
`timescale 1ns/100ps
`default_nettype none
`include "rsc_defines.svh"

module reset_startup_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic hold_rst = 1'b1, pull_run = 1'b0, tap_rst = 1'b0, mem_req = 1'b0;
  logic [3:0] straps = 4'h9;
  logic [1:0] mem_bank = 2'h0;
  logic reset_pin_n, trst_n, reset_output_i, reset_output_o, reset_output_oe_n;
  logic memory_select_two_n, memory_select_three_n, core_run, core_fetch_start, tap_reset;
  logic [1:0] boot_cfg, clk_cfg, ms_pullup_en, boot_mode, startup_ratio, pll_div;
  logic [5:0] pll_mult;
  logic [31:0] core_fetch_addr;
  int miscompares = 0, comparisons = 0, n;

  // Continuous reference clock
  always #2 pclk = !pclk;

  rsc_top u_rsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n), .boot_cfg(boot_cfg), .clk_cfg(clk_cfg),
    .trst_n(trst_n), .reset_output_i(reset_output_i), .reset_output_o(reset_output_o),
    .reset_output_oe_n(reset_output_oe_n), .memory_select_two_n(memory_select_two_n),
    .memory_select_three_n(memory_select_three_n), .ms_pullup_en(ms_pullup_en),
    .mem_req(mem_req), .mem_bank(mem_bank), .core_run(core_run),
    .core_fetch_start(core_fetch_start), .core_fetch_addr(core_fetch_addr),
    .boot_mode(boot_mode), .startup_ratio(startup_ratio), .pll_mult(pll_mult),
    .pll_div(pll_div), .tap_reset(tap_reset));

  rsc_far_side u_rsc_far_side (.hold_rst(hold_rst), .pull_run(pull_run), .straps(straps),
    .tap_rst(tap_rst), .reset_output_o(reset_output_o),
    .reset_output_oe_n(reset_output_oe_n), .reset_pin_n(reset_pin_n), .boot_cfg(boot_cfg),
    .clk_cfg(clk_cfg), .trst_n(trst_n), .reset_output_i(reset_output_i));

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    bit ok;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    ok = (pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge: results settle, next setup never meets this release
    @(posedge pclk);
    if (!ok) begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic wait_run(input logic lvl);
    n = 0;
    while (core_run !== lvl && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      miscompares++;
      close_out();
    end
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `RSC_OFF_PWR, 32'h0);
    chk("pwr ctl rst", 32'h10, rd);
    apb(1'b1, `RSC_OFF_PWR, 32'hff);
    apb(1'b0, `RSC_OFF_PWR, 32'h0);
    chk("pwr ctl in reset", 32'h10, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("boot mode", 32'h2, {30'h0, boot_mode});
    chk("ratio", 32'h1, {30'h0, startup_ratio});
    chk("pin out mode", 32'h0, {31'h0, reset_output_oe_n});
    chk("halted", 32'h0, {31'h0, core_run});
    chk("tap idle", 32'h0, {31'h0, tap_reset});
    hold_rst <= 1'b0;
    @(posedge pclk);
    wait_run(1'b1);
    chk("lock lo", 32'h1, {31'h0, n >= 4096});
    chk("lock hi", 32'h1, {31'h0, n <= 4100});
    chk("fetch start", 32'h1, {31'h0, core_fetch_start});
    chk("fetch addr", `RSC_RESET_VECTOR, core_fetch_addr);
    chk("reset out", 32'h1, {31'h0, reset_output_o});
    apb(1'b1, `RSC_OFF_PWR, 32'h85);
    chk("mult", 32'h05, {26'h0, pll_mult});
    chk("div", 32'h2, {30'h0, pll_div});
    apb(1'b0, `RSC_OFF_STATUS, 32'h0);
    chk("status", 32'hda, rd);
    apb(1'b1, `RSC_OFF_FLAGCTL, 32'h7);
    chk("pullups", 32'h3, {30'h0, ms_pullup_en});
    for (int b = 2; b < 4; b++) begin
      mem_req <= 1'b1;
      mem_bank <= b[1:0];
      @(posedge pclk);
      mem_req <= 1'b0;
      @(posedge pclk);
      chk("select two", {31'h0, b != 2}, {31'h0, memory_select_two_n});
      chk("select three", {31'h0, b != 3}, {31'h0, memory_select_three_n});
    end
    apb(1'b1, `RSC_OFF_FLAGCTL, 32'h6);
    chk("pullups off", 32'h0, {30'h0, ms_pullup_en});
    apb(1'b1, `RSC_OFF_RUNRST, 32'h1);
    @(posedge pclk);
    chk("pin in mode", 32'h1, {31'h0, reset_output_oe_n});
    apb(1'b0, `RSC_OFF_RUNRST, 32'h0);
    chk("run reset enable", 32'h1, rd);
    pull_run <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("run reset", 32'h0, {31'h0, core_run});
    pull_run <= 1'b0;
    wait_run(1'b1);
    chk("relock", 32'h1, {31'h0, n >= 4096});
    tap_rst <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("tap reset", 32'h1, {31'h0, tap_reset});
    close_out();
  end
endmodule

`default_nettype wire
